// ===== core/ddc_pkg.sv
// package for the divide-down clock with advance/delay trim
// assumes a single 40 MHz system clock that also serves as the master clock
package ddc_pkg;

  // ---------------------------------------------------------------
  // counter geometry
  // ---------------------------------------------------------------
  localparam int unsigned LOW_STATES = 16;
  localparam int unsigned HIGH_STATES = 10;
  localparam int unsigned TRIM_CLOCKS = 4;
  localparam logic [3:0] LOW_LAST = 4'(LOW_STATES - 1);
  localparam logic [3:0] HIGH_LAST = 4'(HIGH_STATES - 1);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] LOW_SKIP = 4'(TRIM_CLOCKS);
  localparam logic [2:0] TRIM_LAST = 3'(TRIM_CLOCKS - 1);
  localparam logic [2:0] TRIM_ZERO = 3'h0;

  // ---------------------------------------------------------------
  // trim state machines
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ADV_IDLE,
    ADV_CLEAR,
    ADV_WAIT
  } ddc_adv_state_type;

  typedef enum logic [1:0] {
    DLY_IDLE,
    DLY_HOLD,
    DLY_CLEAR,
    DLY_WAIT
  } ddc_dly_state_type;

  // trim requests and their clear pulses
  typedef struct packed {
    logic advance;
    logic delay;
  } ddc_trim_type;

endpackage : ddc_pkg

// ===== core/ddc_divider.sv
// divide-by-160 pulse generator with four-clock advance and delay trim
// assumes the host holds each request bit until the matching clear pulse
// and that clk_sys stands for the master clock

// How it works
// - with no trim pending one pulse leaves every 160 master clocks.
// - a 16-state low counter carries into a 10-state high counter.
// - the pulse is raised as the high counter wraps from 9 to 0.
// - an advance request skips four low states once, for a 156 clock period.
// - after the skip the advance machine pulses a clear for the advance bit.
// - a delay request holds the counter for four extra master clocks.
// - after the fourth held clock the delay machine pulses the delay clear.
// - divider, advance and delay logic are separate synchronous machines.
module ddc_divider (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // trim requests from host control bits
  input wire ddc_pkg::ddc_trim_type trim_req,
  // trim clear pulses to host
  output ddc_pkg::ddc_trim_type trim_clr,
  // divided output pulse
  output logic pulse_out
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // high counter at its last state, so the next carry launches the pulse
  function automatic logic high_at_last(input logic [3:0] high);
    return (high == ddc_pkg::HIGH_LAST);
  endfunction : high_at_last

  // low counter close enough to the top that a skip runs past it
  function automatic logic skip_wraps(input logic [3:0] low);
    return (low >= (ddc_pkg::LOW_LAST - ddc_pkg::LOW_SKIP));
  endfunction : skip_wraps

  // next high state, wrapping from the last state to zero
  function automatic logic [3:0] high_next(input logic [3:0] high);
    logic [3:0] nxt;
    nxt = high + 4'h1;
    if (high_at_last(high)) begin
      nxt = ddc_pkg::CNT_ZERO;
    end
    return nxt;
  endfunction : high_next

  // ---------------------------------------------------------------
  // reset release and request synchronisers
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  ddc_pkg::ddc_trim_type req_meta_q;
  ddc_pkg::ddc_trim_type req_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      req_meta_q <= '0;
      req_q <= '0;
    end else begin
      req_meta_q <= trim_req;
      req_q <= req_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // advance and delay machines
  // ---------------------------------------------------------------
  ddc_pkg::ddc_adv_state_type adv_q;
  ddc_pkg::ddc_dly_state_type dly_q;
  logic [2:0] hold_cnt_q;
  logic skip_now;
  logic hold_now;

  // skip happens in the single cycle the advance machine leaves idle;
  // it waits out a delay hold, since a frozen counter would lose the skip
  assign skip_now = (adv_q == ddc_pkg::ADV_IDLE) && req_q.advance && !hold_now;
  assign hold_now = (dly_q == ddc_pkg::DLY_HOLD);

  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      adv_q <= ddc_pkg::ADV_IDLE;
    end else begin
      case (adv_q)
        // leaves idle only on the cycle the skip is applied
        ddc_pkg::ADV_IDLE: begin
          if (skip_now) begin
            adv_q <= ddc_pkg::ADV_CLEAR;
          end
        end
        ddc_pkg::ADV_CLEAR: begin
          adv_q <= ddc_pkg::ADV_WAIT;
        end
        // wait for the host bit to drop through the synchroniser
        ddc_pkg::ADV_WAIT: begin
          if (!req_q.advance) begin
            adv_q <= ddc_pkg::ADV_IDLE;
          end
        end
        default: begin
          adv_q <= ddc_pkg::ADV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      dly_q <= ddc_pkg::DLY_IDLE;
    end else begin
      case (dly_q)
        // a delay that meets a skip starts one cycle later
        ddc_pkg::DLY_IDLE: begin
          if (req_q.delay && !skip_now) begin
            dly_q <= ddc_pkg::DLY_HOLD;
          end
        end
        ddc_pkg::DLY_HOLD: begin
          if (hold_cnt_q == ddc_pkg::TRIM_LAST) begin
            dly_q <= ddc_pkg::DLY_CLEAR;
          end
        end
        ddc_pkg::DLY_CLEAR: begin
          dly_q <= ddc_pkg::DLY_WAIT;
        end
        ddc_pkg::DLY_WAIT: begin
          if (!req_q.delay) begin
            dly_q <= ddc_pkg::DLY_IDLE;
          end
        end
        default: begin
          dly_q <= ddc_pkg::DLY_IDLE;
        end
      endcase
    end
  end

  // held clocks, counted only while the delay machine holds
  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      hold_cnt_q <= ddc_pkg::TRIM_ZERO;
    end else if (hold_now) begin
      hold_cnt_q <= hold_cnt_q + 3'h1;
    end else begin
      hold_cnt_q <= ddc_pkg::TRIM_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // clear pulses
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      trim_clr <= '0;
    end else begin
      trim_clr.advance <= (adv_q == ddc_pkg::ADV_CLEAR);
      trim_clr.delay <= (dly_q == ddc_pkg::DLY_CLEAR);
    end
  end

  // ---------------------------------------------------------------
  // main divider
  // ---------------------------------------------------------------
  logic [3:0] low_q;
  logic [3:0] high_q;
  logic [3:0] low_d;
  logic carry;

  // skipping four low states near the top keeps the carry in the same period
  always_comb begin
    carry = 1'b0;
    low_d = low_q + 4'h1;
    if (skip_now && skip_wraps(low_q)) begin
      low_d = low_q + ddc_pkg::LOW_SKIP + 4'h1 - 4'(ddc_pkg::LOW_STATES);
      carry = 1'b1;
    end else if (skip_now) begin
      low_d = low_q + ddc_pkg::LOW_SKIP + 4'h1;
    end else if (low_q == ddc_pkg::LOW_LAST) begin
      low_d = ddc_pkg::CNT_ZERO;
      carry = 1'b1;
    end
  end

  // low counter, frozen while the delay machine holds
  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      low_q <= ddc_pkg::CNT_ZERO;
    end else if (!hold_now) begin
      low_q <= low_d;
    end
  end

  // high counter steps once per low carry
  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      high_q <= ddc_pkg::CNT_ZERO;
    end else if (!hold_now && carry) begin
      high_q <= high_next(high_q);
    end
  end

  // one-cycle pulse on the high wrap; a held cycle never launches it
  always_ff @(posedge clk_sys) begin
    if (!rst_sync_q) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= !hold_now && carry && high_at_last(high_q);
    end
  end

endmodule : ddc_divider

// ===== testbench/ddc_divider_assertions.sv
// checker for the output pulse and the two trim clear pulses
// assumes it is bound onto ddc_divider, one clock domain
module ddc_divider_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // trim and output
  input wire ddc_pkg::ddc_trim_type trim_req,
  input wire ddc_pkg::ddc_trim_type trim_clr,
  input wire logic pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_ca; trim_clr.advance |=> !trim_clr.advance; endproperty
  a_ca: assert property (p_ca) else $error("adv clear too long");
  property p_cd; trim_clr.delay |=> !trim_clr.delay; endproperty
  a_cd: assert property (p_cd) else $error("dly clear too long");
  property p_po; pulse_out |=> !pulse_out [*8]; endproperty
  a_po: assert property (p_po) else $error("pulse too close");
  property p_ra; trim_clr.advance |-> trim_req.advance; endproperty
  a_ra: assert property (p_ra) else $error("adv clear unasked");
  property p_rd; trim_clr.delay |-> trim_req.delay; endproperty
  a_rd: assert property (p_rd) else $error("dly clear unasked");
  property p_ba; $rose(trim_req.advance) |-> ##[2:200] trim_clr.advance; endproperty
  a_ba: assert property (p_ba) else $error("adv clear missing");
  property p_bd; $rose(trim_req.delay) |-> ##[7:400] trim_clr.delay; endproperty
  a_bd: assert property (p_bd) else $error("dly clear missing");
  property p_ld; $rose(trim_req.delay) |-> !trim_clr.delay [*7]; endproperty
  a_ld: assert property (p_ld) else $error("dly clear early");
  c_a: cover property (trim_clr.advance);
  c_d: cover property (trim_clr.delay);
  c_p: cover property (pulse_out);
endmodule : ddc_divider_assertions
bind ddc_divider ddc_divider_assertions chk (.*);

// ===== testbench/ddc_host_model.sv
// host control register holding the advance and delay bits
// assumes set strobes from the bench and clear pulses from the divider
module ddc_host_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // set strobes and clears
  input wire ddc_pkg::ddc_trim_type trim_set,
  input wire ddc_pkg::ddc_trim_type trim_clr,
  // request bits
  output ddc_pkg::ddc_trim_type trim_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // bits held until cleared
  // ----
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) trim_req <= '0;
    else trim_req <= (trim_req & ~trim_clr) | trim_set;
  end
endmodule : ddc_host_model

// ===== testbench/ddc_divider_tb_top.sv
// bench for the divide-by-160 pulse and its trims
// assumes the host model answers the clear pulses
module ddc_divider_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  ddc_pkg::ddc_trim_type trim_set = '0;
  ddc_pkg::ddc_trim_type trim_req;
  ddc_pkg::ddc_trim_type trim_clr;
  logic pulse_out;
  logic [8:0] n;
  logic [8:0] m;
  int error_cnt = 0;
  int n_tests = 0;
  ddc_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .trim_set(trim_set),
    .trim_clr(trim_clr), .trim_req(trim_req));
  ddc_divider dut (.clk_sys(clk_sys), .rst_n(rst_n), .trim_req(trim_req),
    .trim_clr(trim_clr), .pulse_out(pulse_out));
  initial forever #12.5 clk_sys = ~clk_sys;
  // ----
  // tasks
  // ----
  task complete_run;
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task check(input logic [8:0] s, input logic [8:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  // cycles up to and including the next pulse
  task gap(input logic [8:0] s, output logic [8:0] c);
    int i;
    c = s;
    for (i = 0; i < 400 && pulse_out !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    if (i == 400) begin
      error_cnt++;
      complete_run();
    end else begin
      @(posedge clk_sys);
      #1;
    end
  endtask : gap
  task run(input logic [1:0] cmd, input logic [8:0] p, input logic [8:0] sum);
    gap(9'h1, n);
    @(posedge clk_sys) trim_set <= ddc_pkg::ddc_trim_type'(cmd);
    @(posedge clk_sys) trim_set <= '0;
    #1;
    gap(9'h3, n);
    gap(9'h1, m);
    if (p != 9'h0) check(n, p);
    check(n + m, sum);
    check(9'(trim_req), 9'h0);
  endtask : run
  task t_nominal;
    run(2'b00, 9'ha0, 9'h140);
  endtask : t_nominal
  task t_adv;
    run(2'b10, 9'h9c, 9'h13c);
  endtask : t_adv
  task t_dly;
    run(2'b01, 9'ha4, 9'h144);
  endtask : t_dly
  task t_both;
    run(2'b11, 9'ha0, 9'h140);
  endtask : t_both
  task t_reset;
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check({7'h0, trim_clr}, 9'h0);
    check({8'h0, pulse_out}, 9'h0);
    @(posedge clk_sys) rst_n <= 1'b1;
  endtask : t_reset
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_nominal();
    t_adv();
    t_dly();
    t_both();
    t_reset();
    t_nominal();
    complete_run();
  end
endmodule : ddc_divider_tb_top
